//--- inc/vc0_res_pkg.sv
package vc0_res_pkg;

	// ************************************************************
	// register offsets (byte addresses in configuration space)
	// ************************************************************
	localparam int          CFG_ADDR_W    = 12;
	localparam logic [11:0] CTRL_OFS      = 12'h214;
	localparam logic [11:0] STS_OFS       = 12'h218;

	// ************************************************************
	// control register field positions
	// ************************************************************
	localparam int TC_MAP_LSB    = 0;
	localparam int TC_MAP_W      = 8;
	localparam int LOAD_CMD_BIT  = 16;
	localparam int ARB_SEL_LSB   = 17;
	localparam int ARB_SEL_W     = 3;
	localparam int CHAN_ID_LSB   = 24;
	localparam int CHAN_ID_W     = 3;
	localparam int CHAN_EN_BIT   = 31;

	// ************************************************************
	// status register field positions
	// ************************************************************
	localparam int TABLE_STS_BIT = 16;
	localparam int NEG_PEND_BIT  = 17;

	// ************************************************************
	// reset and hardwired values
	// ************************************************************
	localparam logic [7:0]  TC_MAP_RST    = 8'hFF;
	localparam logic [7:0]  TC_MAP_RO     = 8'h01;
	localparam logic [2:0]  ARB_SEL_RST   = 3'h0;
	localparam logic [2:0]  CHAN_ID_VAL   = 3'h0;
	localparam logic        CHAN_EN_VAL   = 1'b1;
	localparam logic        NEG_PEND_VAL  = 1'b0;
	localparam logic        TABLE_STS_RST = 1'b0;
	localparam logic [7:0]  ARB_CAP_RST   = 8'h01;
	localparam logic [7:0]  TABLE_SCHEMES = 8'hFE;
	localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

	// ************************************************************
	// table copy defaults
	// ************************************************************
	localparam int TABLE_DEPTH   = 8;
	localparam int ENTRY_W       = 4;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic                  valid;
		logic                  write;
		logic [CFG_ADDR_W-1:0] addr;
		logic [3:0]            be;
		logic [31:0]           wdata;
	} cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} cfg_rsp_t;

	typedef enum logic [1:0] {
		COPY_IDLE,
		COPY_READ,
		COPY_WRITE
	} copy_state_t;

endpackage

//--- hw/arb_table_copier.sv
`timescale 1ns/1ns
module arb_table_copier #(
	parameter int DEPTH = vc0_res_pkg::TABLE_DEPTH,
	parameter int WIDTH = vc0_res_pkg::ENTRY_W
) (
	// clock and reset
	input  wire logic                     clk_sys_i,
	input  wire logic                     rst_i,
	// control
	input  wire logic                     start_i,
	output logic                          busy_o,
	output logic                          done_o,
	// stored table read port, data one cycle after index
	output logic [$clog2(DEPTH)-1:0]      tbl_rd_idx_o,
	input  wire logic [WIDTH-1:0]         tbl_rd_data_i,
	// arbitration logic load port
	output logic                          arb_we_o,
	output logic [$clog2(DEPTH)-1:0]      arb_idx_o,
	output logic [WIDTH-1:0]              arb_data_o
);
	localparam int IW = $clog2(DEPTH);
	localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);

	vc0_res_pkg::copy_state_t state;
	vc0_res_pkg::copy_state_t next_state;
	logic [IW-1:0]            idx;
	logic [IW-1:0]            next_idx;
	logic                     done;
	logic                     next_done;
	logic                     we;
	logic                     next_we;
	logic [WIDTH-1:0]         data;
	logic [WIDTH-1:0]         next_data;
	logic [IW-1:0]            widx;
	logic [IW-1:0]            next_widx;

	always_comb begin
		next_state = state;
		next_idx   = idx;
		next_done  = 1'b0;
		next_we    = 1'b0;
		next_data  = data;
		next_widx  = widx;
		unique case (state)
			vc0_res_pkg::COPY_IDLE: begin
				if (start_i) begin
					next_idx   = '0;
					next_state = vc0_res_pkg::COPY_READ;
				end
			end
			vc0_res_pkg::COPY_READ: begin
				next_state = vc0_res_pkg::COPY_WRITE;
			end
			vc0_res_pkg::COPY_WRITE: begin
				next_we   = 1'b1;
				next_data = tbl_rd_data_i;
				next_widx = idx;
				if (idx == LAST) begin
					next_done  = 1'b1;
					next_state = vc0_res_pkg::COPY_IDLE;
				end else begin
					next_idx   = idx + IW'(1);
					next_state = vc0_res_pkg::COPY_READ;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state <= vc0_res_pkg::COPY_IDLE;
			idx   <= '0;
			done  <= 1'b0;
			we    <= 1'b0;
			data  <= '0;
			widx  <= '0;
		end else begin
			state <= next_state;
			idx   <= next_idx;
			done  <= next_done;
			we    <= next_we;
			data  <= next_data;
			widx  <= next_widx;
		end
	end

	// done rides with the last entry's write
	assign busy_o       = (state != vc0_res_pkg::COPY_IDLE) || we;
	assign done_o       = done;
	assign tbl_rd_idx_o = idx;
	assign arb_we_o     = we;
	assign arb_idx_o    = widx;
	assign arb_data_o   = data;

endmodule // arb_table_copier

//--- hw/vc0_resource_ctrl_status.sv
`timescale 1ns/1ns

module vc0_resource_ctrl_status #(
	parameter logic [7:0] PORT_ARB_CAP  = vc0_res_pkg::ARB_CAP_RST,
	parameter logic [7:0] TABLE_SCHEMES = vc0_res_pkg::TABLE_SCHEMES,
	parameter int         TABLE_DEPTH   = vc0_res_pkg::TABLE_DEPTH,
	parameter int         ENTRY_W       = vc0_res_pkg::ENTRY_W
) (
	// clock and reset
	input  wire logic                         clk_sys_i,
	input  wire logic                         rst_i,
	// configuration access port
	input  wire vc0_res_pkg::cfg_req_t        cfg_req_i,
	output vc0_res_pkg::cfg_rsp_t             cfg_rsp_o,
	// port arbitration table write strobe from table storage
	input  wire logic                         arb_table_written_i,
	// stored table read port
	output logic [$clog2(TABLE_DEPTH)-1:0]    tbl_rd_idx_o,
	input  wire logic [ENTRY_W-1:0]           tbl_rd_data_i,
	// arbitration logic load port
	output logic                              arb_load_we_o,
	output logic [$clog2(TABLE_DEPTH)-1:0]    arb_load_idx_o,
	output logic [ENTRY_W-1:0]                arb_load_data_o,
	// configuration seen by the datapath
	output logic [7:0]                        traffic_class_channel_map_o,
	output logic [2:0]                        port_arb_select_o,
	output logic                              channel_enable_bit_o,
	output logic                              port_arb_table_status_o
);

	// ************************************************************
	// decode
	// ************************************************************
	logic hit_ctrl;
	logic hit_sts;
	logic wr_ctrl;
	logic rd_any;

	assign hit_ctrl = cfg_req_i.addr == vc0_res_pkg::CTRL_OFS;
	assign hit_sts  = cfg_req_i.addr == vc0_res_pkg::STS_OFS;
	assign wr_ctrl  = cfg_req_i.valid && cfg_req_i.write && hit_ctrl;
	assign rd_any   = cfg_req_i.valid && !cfg_req_i.write;

	// lanes 1 and 3 carry only reserved and hardwired bits, so they need no strobe
	logic wr_map_lane;
	logic wr_cmd_lane;

	assign wr_map_lane = wr_ctrl && cfg_req_i.be[0];
	assign wr_cmd_lane = wr_ctrl && cfg_req_i.be[2];

	// ************************************************************
	// class map write value, one bit per traffic class
	// ************************************************************
	logic [7:0] map_wr_value;

	for (genvar b = 0; b < vc0_res_pkg::TC_MAP_W; b++) begin : g_map_bit
		if (vc0_res_pkg::TC_MAP_RO[b]) begin : g_fixed
			// class 0 always travels on channel 0, so its bit cannot be cleared
			assign map_wr_value[b] = 1'b1;
		end else begin : g_open
			assign map_wr_value[b] = cfg_req_i.wdata[vc0_res_pkg::TC_MAP_LSB + b];
		end
	end

	// ************************************************************
	// control register state
	// ************************************************************
	logic [7:0] traffic_class_channel_map;
	logic [7:0] next_traffic_class_channel_map;
	logic [2:0] port_arb_select;
	logic [2:0] next_port_arb_select;
	logic       load_port_arb_table;
	logic       table_used;

	always_comb begin
		next_traffic_class_channel_map = traffic_class_channel_map;
		next_port_arb_select           = port_arb_select;
		if (wr_map_lane) begin
			next_traffic_class_channel_map = map_wr_value;
		end
		if (wr_cmd_lane) begin
			// stored as written; legality against the capability is software's duty
			next_port_arb_select = cfg_req_i.wdata[vc0_res_pkg::ARB_SEL_LSB +: vc0_res_pkg::ARB_SEL_W];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			traffic_class_channel_map <= vc0_res_pkg::TC_MAP_RST;
			port_arb_select           <= vc0_res_pkg::ARB_SEL_RST;
		end else begin
			traffic_class_channel_map <= next_traffic_class_channel_map;
			port_arb_select           <= next_port_arb_select;
		end
	end

	// ************************************************************
	// table load command
	// ************************************************************
	// a write of zero, or a write without the byte lane, starts nothing
	assign load_port_arb_table = wr_cmd_lane && cfg_req_i.wdata[vc0_res_pkg::LOAD_CMD_BIT];

	// scheme must be both capable and table based; checked against the select
	// in force when the command arrives, not the one written alongside it
	assign table_used = PORT_ARB_CAP[port_arb_select] && TABLE_SCHEMES[port_arb_select];

	logic copy_start;
	logic copy_busy;
	logic copy_done;

	// a command during a copy in flight is dropped, not queued
	assign copy_start = load_port_arb_table && table_used && !copy_busy;

	arb_table_copier #(
		.DEPTH (TABLE_DEPTH),
		.WIDTH (ENTRY_W)
	) arb_table_copier_inst (
		.clk_sys_i     (clk_sys_i),
		.rst_i         (rst_i),
		.start_i       (copy_start),
		.busy_o        (copy_busy),
		.done_o        (copy_done),
		.tbl_rd_idx_o  (tbl_rd_idx_o),
		.tbl_rd_data_i (tbl_rd_data_i),
		.arb_we_o      (arb_load_we_o),
		.arb_idx_o     (arb_load_idx_o),
		.arb_data_o    (arb_load_data_o)
	);

	// ************************************************************
	// table coherency status
	// ************************************************************
	logic port_arb_table_status;
	logic next_port_arb_table_status;

	always_comb begin
		next_port_arb_table_status = port_arb_table_status;
		if (copy_done) begin
			next_port_arb_table_status = 1'b0;
		end
		// a table write in the finishing cycle leaves the table stale again
		if (arb_table_written_i) begin
			next_port_arb_table_status = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			port_arb_table_status <= vc0_res_pkg::TABLE_STS_RST;
		end else begin
			port_arb_table_status <= next_port_arb_table_status;
		end
	end

	// ************************************************************
	// read data
	// ************************************************************
	logic [31:0] ctrl_view;
	logic [31:0] sts_view;
	logic [31:0] rd_mux;

	always_comb begin
		ctrl_view = 32'h0000_0000;
		ctrl_view[vc0_res_pkg::TC_MAP_LSB +: vc0_res_pkg::TC_MAP_W] = traffic_class_channel_map;
		ctrl_view[vc0_res_pkg::LOAD_CMD_BIT] = 1'b0;
		ctrl_view[vc0_res_pkg::ARB_SEL_LSB +: vc0_res_pkg::ARB_SEL_W] = port_arb_select;
		ctrl_view[vc0_res_pkg::CHAN_ID_LSB +: vc0_res_pkg::CHAN_ID_W] = vc0_res_pkg::CHAN_ID_VAL;
		ctrl_view[vc0_res_pkg::CHAN_EN_BIT] = vc0_res_pkg::CHAN_EN_VAL;
	end

	always_comb begin
		sts_view = 32'h0000_0000;
		sts_view[vc0_res_pkg::TABLE_STS_BIT] = port_arb_table_status;
		// channel 0 is never negotiated, so nothing here can show progress
		sts_view[vc0_res_pkg::NEG_PEND_BIT] = vc0_res_pkg::NEG_PEND_VAL;
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux = ctrl_view;
		end else if (hit_sts) begin
			rd_mux = sts_view;
		end
	end

	// ************************************************************
	// response
	// ************************************************************
	// every request, mapped or not, is answered one cycle later;
	// unmapped reads return zero and unmapped writes are dropped
	logic        ack;
	logic        next_ack;
	logic [31:0] rdata;
	logic [31:0] next_rdata;

	always_comb begin
		next_ack   = cfg_req_i.valid;
		next_rdata = rdata;
		if (rd_any) begin
			next_rdata = rd_mux;
		end else if (cfg_req_i.valid) begin
			next_rdata = vc0_res_pkg::RDATA_RST;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ack   <= 1'b0;
			rdata <= vc0_res_pkg::RDATA_RST;
		end else begin
			ack   <= next_ack;
			rdata <= next_rdata;
		end
	end

	assign cfg_rsp_o.ack   = ack;
	assign cfg_rsp_o.rdata = rdata;

	// ************************************************************
	// datapath view
	// ************************************************************
	assign traffic_class_channel_map_o = traffic_class_channel_map;
	assign port_arb_select_o           = port_arb_select;
	assign channel_enable_bit_o        = vc0_res_pkg::CHAN_EN_VAL;
	assign port_arb_table_status_o     = port_arb_table_status;

endmodule // vc0_resource_ctrl_status

//--- verification/vc0_resource_ctrl_status_properties.sv
`timescale 1ns/1ns
module vc0_resource_ctrl_status_checker #(
	parameter logic [7:0] PORT_ARB_CAP  = 8'h01,
	parameter logic [7:0] TABLE_SCHEMES = 8'hFE,
	parameter int         TABLE_DEPTH   = 8,
	parameter int         ENTRY_W       = 4
) (
	// clock and reset
	input wire logic                               clk_sys_i,
	input wire logic                               rst_i,
	// configuration port
	input wire vc0_res_pkg::cfg_req_t              cfg_req_i,
	input wire vc0_res_pkg::cfg_rsp_t              cfg_rsp_o,
	// table ports
	input wire logic                               arb_table_written_i,
	input wire logic [$clog2(TABLE_DEPTH)-1:0]     tbl_rd_idx_o,
	input wire logic [ENTRY_W-1:0]                 tbl_rd_data_i,
	input wire logic                               arb_load_we_o,
	input wire logic [$clog2(TABLE_DEPTH)-1:0]     arb_load_idx_o,
	input wire logic [ENTRY_W-1:0]                 arb_load_data_o,
	// datapath view
	input wire logic [7:0]                         traffic_class_channel_map_o,
	input wire logic [2:0]                         port_arb_select_o,
	input wire logic                               channel_enable_bit_o,
	input wire logic                               port_arb_table_status_o
);
	localparam int IW = $clog2(TABLE_DEPTH);
	logic rd_ctrl, rd_sts, wr_ctrl, start, cap_ok, last, busy_h, next_busy_h;
	assign rd_ctrl = cfg_req_i.valid && !cfg_req_i.write && cfg_req_i.addr == vc0_res_pkg::CTRL_OFS;
	assign rd_sts  = cfg_req_i.valid && !cfg_req_i.write && cfg_req_i.addr == vc0_res_pkg::STS_OFS;
	assign wr_ctrl = cfg_req_i.valid && cfg_req_i.write && cfg_req_i.addr == vc0_res_pkg::CTRL_OFS;
	assign start   = wr_ctrl && cfg_req_i.be[2] && cfg_req_i.wdata[16];
	// select is judged before the write lands
	assign cap_ok  = PORT_ARB_CAP[port_arb_select_o] && TABLE_SCHEMES[port_arb_select_o] && !busy_h;
	assign last    = arb_load_we_o && arb_load_idx_o == IW'(TABLE_DEPTH - 1);
	always_comb begin
		next_busy_h = busy_h;
		if (last)
			next_busy_h = 1'b0;
		else if (start && cap_ok)
			next_busy_h = 1'b1;
	end
	always_ff @(posedge clk_sys_i) begin
		busy_h <= rst_i ? 1'b0 : next_busy_h;
	end
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_cmd; start && cap_ok; endsequence
	sequence s_first_entry; ##1 tbl_rd_idx_o == '0 ##2 arb_load_we_o && arb_load_idx_o == '0; endsequence
	property p_rd_ctrl; rd_ctrl |=> cfg_rsp_o.rdata == {1'b1, 7'h00, 4'h0,
		$past(port_arb_select_o), 1'b0, 8'h00, $past(traffic_class_channel_map_o)}; endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read view wrong");
	property p_rd_sts; rd_sts |=> cfg_rsp_o.rdata == {15'h0, $past(port_arb_table_status_o), 16'h0}; endproperty
	a_rd_sts: assert property (p_rd_sts) else $error("status read view wrong");
	property p_map_wr; wr_ctrl && cfg_req_i.be[0] |=>
		traffic_class_channel_map_o == {$past(cfg_req_i.wdata[7:1]), 1'b1}; endproperty
	a_map_wr: assert property (p_map_wr) else $error("class map write wrong");
	property p_sel_wr; wr_ctrl && cfg_req_i.be[2] |=> port_arb_select_o == $past(cfg_req_i.wdata[19:17]); endproperty
	a_sel_wr: assert property (p_sel_wr) else $error("select write wrong");
	property p_sts_set; arb_table_written_i |=> port_arb_table_status_o; endproperty
	a_sts_set: assert property (p_sts_set) else $error("table status not set");
	property p_sts_hold; port_arb_table_status_o && !arb_load_we_o |=> port_arb_table_status_o; endproperty
	a_sts_hold: assert property (p_sts_hold) else $error("table status dropped early");
	property p_clear; last && !arb_table_written_i |=> !port_arb_table_status_o; endproperty
	a_clear: assert property (p_clear) else $error("table status not cleared");
	property p_load; s_cmd |-> s_first_entry; endproperty
	a_load: assert property (p_load) else $error("table copy did not start");
	property p_no_start; !busy_h && !(start && cap_ok) |=> !arb_load_we_o [*3]; endproperty
	a_no_start: assert property (p_no_start) else $error("copy without valid command");
	property p_enable; channel_enable_bit_o; endproperty
	a_enable: assert property (p_enable) else $error("channel enable low");
endmodule // vc0_resource_ctrl_status_checker

bind vc0_resource_ctrl_status vc0_resource_ctrl_status_checker #(
	.PORT_ARB_CAP(PORT_ARB_CAP), .TABLE_SCHEMES(TABLE_SCHEMES), .TABLE_DEPTH(TABLE_DEPTH), .ENTRY_W(ENTRY_W)
) vc0_resource_ctrl_status_checker_inst (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_req_i(cfg_req_i), .cfg_rsp_o(cfg_rsp_o),
	.arb_table_written_i(arb_table_written_i), .tbl_rd_idx_o(tbl_rd_idx_o), .tbl_rd_data_i(tbl_rd_data_i),
	.arb_load_we_o(arb_load_we_o), .arb_load_idx_o(arb_load_idx_o), .arb_load_data_o(arb_load_data_o),
	.traffic_class_channel_map_o(traffic_class_channel_map_o), .port_arb_select_o(port_arb_select_o),
	.channel_enable_bit_o(channel_enable_bit_o), .port_arb_table_status_o(port_arb_table_status_o)
);

//--- verification/tb_vc0_resource_ctrl_status.sv
`timescale 1ns/1ns
module tb_vc0_resource_ctrl_status;
	localparam int          DEPTH = 4;
	localparam logic [11:0] CTRL  = vc0_res_pkg::CTRL_OFS;
	localparam logic [11:0] STS   = vc0_res_pkg::STS_OFS;
	logic                   clk_sys_i           = 1'b0;
	logic                   rst_i               = 1'b1;
	vc0_res_pkg::cfg_req_t  cfg_req_i           = '0;
	vc0_res_pkg::cfg_rsp_t  cfg_rsp_o;
	logic                   arb_table_written_i = 1'b0;
	logic [3:0]             tbl_rd_data_i       = 4'h0;
	logic [3:0]             arb_load_data_o;
	logic [1:0]             tbl_rd_idx_o;
	logic [1:0]             arb_load_idx_o;
	logic                   arb_load_we_o;
	logic                   channel_enable_bit_o;
	logic                   port_arb_table_status_o;
	logic [7:0]             traffic_class_channel_map_o;
	logic [2:0]             port_arb_select_o;
	logic [31:0]            rd;
	int                     failures = 0;
	int                     check_count = 0;
	int                     cycles = 0;
	int                     we_seen = 0;

	always #50 clk_sys_i = ~clk_sys_i;

	// scheme 1 made capable so copies really run
	vc0_resource_ctrl_status #(.PORT_ARB_CAP(8'h03), .TABLE_DEPTH(DEPTH)) vc0_resource_ctrl_status_inst (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_req_i(cfg_req_i), .cfg_rsp_o(cfg_rsp_o),
		.arb_table_written_i(arb_table_written_i), .tbl_rd_idx_o(tbl_rd_idx_o), .tbl_rd_data_i(tbl_rd_data_i),
		.arb_load_we_o(arb_load_we_o), .arb_load_idx_o(arb_load_idx_o), .arb_load_data_o(arb_load_data_o),
		.traffic_class_channel_map_o(traffic_class_channel_map_o), .port_arb_select_o(port_arb_select_o),
		.channel_enable_bit_o(channel_enable_bit_o), .port_arb_table_status_o(port_arb_table_status_o)
	);

	// ****
	// table storage and copy monitor
	// ****
	always @(posedge clk_sys_i) tbl_rd_data_i <= 4'hF - {2'b00, tbl_rd_idx_o};
	always @(negedge clk_sys_i) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			stop_test();
		end else if (arb_load_we_o === 1'b1) begin
			chk(32'(we_seen), {30'h0, arb_load_idx_o});
			chk(32'(15 - we_seen), {28'h0, arb_load_data_o});
			we_seen++;
		end
	end

	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic acc(input logic wr, input logic [11:0] a, input logic [3:0] be, input logic [31:0] wd);
		@(posedge clk_sys_i) #10;
		cfg_req_i = '{valid: 1'b1, write: wr, addr: a, be: be, wdata: wd};
		@(posedge clk_sys_i) #10;
		cfg_req_i.valid = 1'b0;
		chk(32'h1, {31'h0, cfg_rsp_o.ack});
		rd = cfg_rsp_o.rdata;
	endtask
	task automatic rdr(input logic [11:0] a, input logic [31:0] exp);
		acc(1'b0, a, 4'h0, 32'h0);
		chk(exp, rd);
	endtask
	task automatic stop_test();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset();
		chk(32'h0000_00FF, {24'h0, traffic_class_channel_map_o});
		chk(32'h1, {31'h0, channel_enable_bit_o});
		rdr(CTRL, 32'h8000_00FF);
		rdr(STS, 32'h0);
	endtask
	task automatic t_ctrl();
		// load bit set while round robin, which has no table, is still selected
		acc(1'b1, CTRL, 4'hF, 32'hFFF3_FF00);
		rdr(CTRL, 32'h8002_0001);
		// select 1 lands as written although the load was refused
		chk(32'h1, {29'h0, port_arb_select_o});
		acc(1'b1, CTRL, 4'hB, 32'h0000_00AA);
		rdr(CTRL, 32'h8002_00AB);
		chk(32'h0, 32'(we_seen));
	endtask
	task automatic t_status();
		@(posedge clk_sys_i) #10;
		arb_table_written_i = 1'b1;
		@(posedge clk_sys_i) #10;
		arb_table_written_i = 1'b0;
		rdr(STS, 32'h0001_0000);
		acc(1'b1, CTRL, 4'h4, 32'h0002_0000);
		rdr(STS, 32'h0001_0000);
		// a wrongly started copy shows its first write only three edges on
		repeat (3) @(posedge clk_sys_i);
		chk(32'h0, 32'(we_seen));
	endtask
	task automatic t_load();
		acc(1'b1, CTRL, 4'h4, 32'h0003_0000);
		// second command lands mid-copy and must be dropped
		acc(1'b1, CTRL, 4'h4, 32'h0003_0000);
		repeat (20) begin
			acc(1'b0, STS, 4'h0, 32'h0);
			if (rd[16] === 1'b0)
				break;
		end
		chk(32'h0, rd);
		chk(32'(DEPTH), 32'(we_seen));
		rdr(CTRL, 32'h8002_00AB);
	endtask
	task automatic t_unmapped();
		acc(1'b1, 12'h21C, 4'hF, 32'hFFFF_FFFF);
		rdr(12'h21C, 32'h0);
		acc(1'b1, STS, 4'hF, 32'hFFFF_FFFF);
		rdr(STS, 32'h0);
		rdr(CTRL, 32'h8002_00AB);
	endtask

	initial begin
		repeat (4) @(posedge clk_sys_i);
		#10;
		rst_i = 1'b0;
		t_reset();
		t_ctrl();
		t_status();
		t_load();
		t_unmapped();
		stop_test();
	end
endmodule // tb_vc0_resource_ctrl_status
